// ---- core/smrc_defs.svh ----
// Constants for the switch monitor run-control register
//
// Operation
// - Setting the run bit (bit 11) starts normal operation: wetting current and input polling.
// - Clearing the run bit halts operation and keeps the device idle until the bit is set again.
// - Configuration writes while running are not blocked and may give wrong states or spurious interrupts.
// - While running, writes to the run bit, checksum trigger, reset bit and compare-check config are accepted.
// - The periodic enable (bit 10) selects continuous mode at zero and periodic polling at one.
// - Writing one to the checksum trigger (bit 9) starts a checksum over all configuration bits.
// - When the checksum completes, the done flag is set and the active-low interrupt pin goes low.
// - The computed checksum is readable in the result register once computation ends.
// - The checksum trigger bit clears by itself once the checksum has been executed.
// - The sample-on duration field (bits 8-5) encodes 64us steps for 0-7, then 640/768/896/1024/2048us, else 512us.
// - The polling period field (bits 4-1) encodes 2 to 4096ms for codes 0-C and 8ms for higher codes.
// - Writing one to the reset bit (bit 0) performs a software reset; writing zero does nothing.
`ifndef SMRC_DEFS_SVH
`define SMRC_DEFS_SVH

// ----------------------------------------
// Register location and fields
// ----------------------------------------
`define SMRC_CFG_OFFSET 8'h1A
`define SMRC_CFG_RESET 12'h000
`define SMRC_BIT_RUN 11
`define SMRC_BIT_PERIODIC 10
`define SMRC_BIT_CRC 9
`define SMRC_ACT_HI 8
`define SMRC_ACT_LO 5
`define SMRC_PER_HI 4
`define SMRC_PER_LO 1
`define SMRC_BIT_RESET 0
`define SMRC_CFG_W 12
`define SMRC_REG_W 24
`define SMRC_CRC_W 16

// ----------------------------------------
// Timing
// ----------------------------------------
`define SMRC_CLK_PERIOD_NS 25
`define SMRC_TICK_NS 1000
`define SMRC_TICK_CYCLES (`SMRC_TICK_NS / `SMRC_CLK_PERIOD_NS)
`define SMRC_US_PER_MS 1000
`define SMRC_US_W 23

`endif

// ---- core/smrc_pkg.sv ----
// Types shared by the switch monitor run-control block
`include "smrc_defs.svh"
package smrc_pkg;

  // Sampling phase of the polling sequencer
  typedef enum logic [1:0] {SMRC_IDLE, SMRC_SAMPLE, SMRC_WAIT} smrc_phase_type;

  // Register write request from the serial front end
  typedef struct packed {
    logic en;
    logic [`SMRC_REG_W-1:0] data;
  } smrc_wr_type;

  // Checksum engine answer
  typedef struct packed {
    logic done;
    logic [`SMRC_CRC_W-1:0] value;
  } smrc_crc_type;

  // Whole block state
  typedef struct packed {
    logic [`SMRC_CFG_W-1:0] cfg;
    logic busy;
    logic crc_start;
    logic sw_rst;
    logic done_flag;
    logic [`SMRC_CRC_W-1:0] crc_res;
    logic [15:0] tick_cnt;
    logic [`SMRC_US_W-1:0] us_cnt;
    smrc_phase_type phase;
  } smrc_state_type;

endpackage

// ---- core/smrc_top.sv ----
// Run control, sampling sequencer and checksum trigger for the switch monitor
`timescale 1ns/1ps
`include "smrc_defs.svh"
module smrc_top #(
  parameter int TICK_CYCLES = `SMRC_TICK_CYCLES
) (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire smrc_pkg::smrc_wr_type wr_in,
  input wire smrc_pkg::smrc_crc_type crc_in,
  input wire logic flag_clear_in,
  output logic [`SMRC_REG_W-1:0] cfg_rd_out,
  output logic run_out,
  output logic periodic_out,
  output logic wetting_on_out,
  output logic crc_start_out,
  output logic [`SMRC_CRC_W-1:0] crc_result_out,
  output logic checksum_done_flag_out,
  output logic int_n_out,
  output logic sw_reset_out
);
  import smrc_pkg::*;

  // ----------------------------------------
  // Elaboration checks
  // ----------------------------------------
  if (TICK_CYCLES < 1 || TICK_CYCLES > 65535)
  begin : g_bad_tick
    $error("TICK_CYCLES out of range");
  end

  // ----------------------------------------
  // Code tables
  // ----------------------------------------
  // Sample-on duration in microseconds
  function automatic logic [`SMRC_US_W-1:0] act_us(input logic [3:0] code);
    logic [`SMRC_US_W-1:0] r;
    r = `SMRC_US_W'h200;
    if (code <= 4'h7)
      r = `SMRC_US_W'(({19'h00000, code} + `SMRC_US_W'h1) * `SMRC_US_W'h40);
    else
    begin
      unique case (code)
        4'h8: r = `SMRC_US_W'h280;
        4'h9: r = `SMRC_US_W'h300;
        4'hA: r = `SMRC_US_W'h380;
        4'hB: r = `SMRC_US_W'h400;
        4'hC: r = `SMRC_US_W'h800;
        default: r = `SMRC_US_W'h200;
      endcase
    end
    return r;
  endfunction

  // Polling period in microseconds
  function automatic logic [`SMRC_US_W-1:0] period_us(input logic [3:0] code);
    logic [12:0] ms;
    unique case (code)
      4'h0: ms = 13'h0002;
      4'h1: ms = 13'h0004;
      4'h2: ms = 13'h0008;
      4'h3: ms = 13'h0010;
      4'h4: ms = 13'h0020;
      4'h5: ms = 13'h0030;
      4'h6: ms = 13'h0040;
      4'h7: ms = 13'h0080;
      4'h8: ms = 13'h0100;
      4'h9: ms = 13'h0200;
      4'hA: ms = 13'h0400;
      4'hB: ms = 13'h0800;
      4'hC: ms = 13'h1000;
      default: ms = 13'h0008;
    endcase
    return `SMRC_US_W'({10'h000, ms} * `SMRC_US_W'(`SMRC_US_PER_MS));
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  smrc_state_type q;
  smrc_state_type d;
  logic tick;
  logic crc_finish;
  logic [`SMRC_US_W-1:0] us_next;
  logic [`SMRC_US_W-1:0] win_us;
  logic [`SMRC_US_W-1:0] per_us;

  // Next-state logic
  always_comb
  begin
    d = q;
    d.crc_start = 1'b0;
    d.sw_rst = 1'b0;
    win_us = act_us(q.cfg[`SMRC_ACT_HI:`SMRC_ACT_LO]);
    per_us = period_us(q.cfg[`SMRC_PER_HI:`SMRC_PER_LO]);
    us_next = q.us_cnt + `SMRC_US_W'h1;
    crc_finish = q.busy && crc_in.done;
    // Microsecond tick divider
    tick = (q.tick_cnt == 16'(TICK_CYCLES - 1));
    d.tick_cnt = tick ? 16'h0000 : q.tick_cnt + 16'h0001;
    // Checksum launch and completion
    if (q.cfg[`SMRC_BIT_CRC] && !q.busy)
    begin
      d.busy = 1'b1;
      d.crc_start = 1'b1;
    end
    if (flag_clear_in)
      d.done_flag = 1'b0;
    if (crc_finish)
    begin
      d.busy = 1'b0;
      d.cfg[`SMRC_BIT_CRC] = 1'b0;
      d.done_flag = 1'b1;
      d.crc_res = crc_in.value;
    end
    // Sampling sequencer, runs only with the run bit set
    if (!q.cfg[`SMRC_BIT_RUN])
    begin
      d.phase = SMRC_IDLE;
      d.us_cnt = `SMRC_US_W'h0;
    end
    else
    begin
      unique case (q.phase)
        SMRC_IDLE:
        begin
          d.phase = SMRC_SAMPLE;
          d.us_cnt = `SMRC_US_W'h0;
        end
        SMRC_SAMPLE:
        begin
          if (q.cfg[`SMRC_BIT_PERIODIC] && tick)
          begin
            d.us_cnt = us_next;
            if (us_next >= win_us)
              d.phase = SMRC_WAIT;
          end
        end
        SMRC_WAIT:
        begin
          if (tick)
          begin
            d.us_cnt = us_next;
            if (us_next >= per_us)
            begin
              d.phase = SMRC_SAMPLE;
              d.us_cnt = `SMRC_US_W'h0;
            end
          end
        end
      endcase
    end
    // Register write; accepted in any run state, no guard
    if (wr_in.en)
    begin
      d.cfg = wr_in.data[`SMRC_CFG_W-1:0];
      if (wr_in.data[`SMRC_BIT_RESET])
      begin
        d.cfg = `SMRC_CFG_RESET;
        d.busy = 1'b0;
        d.done_flag = 1'b0;
        d.phase = SMRC_IDLE;
        d.us_cnt = `SMRC_US_W'h0;
        d.sw_rst = 1'b1;
      end
    end
  end

  // State register
  always_ff @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      q <= '0;
      q.phase <= SMRC_IDLE;
    end
    else
      q <= d;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign cfg_rd_out = {12'h000, q.cfg}; // Upper fields not held here
  assign run_out = q.cfg[`SMRC_BIT_RUN];
  assign periodic_out = q.cfg[`SMRC_BIT_PERIODIC];
  assign wetting_on_out = (q.phase == SMRC_SAMPLE);
  assign crc_start_out = q.crc_start;
  assign crc_result_out = q.crc_res;
  assign checksum_done_flag_out = q.done_flag;
  assign int_n_out = ~q.done_flag;
  assign sw_reset_out = q.sw_rst;

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (reset_in);

  logic soft_wr;
  assign soft_wr = wr_in.en && wr_in.data[`SMRC_BIT_RESET];

  a_soft_reset_clears: assert property (soft_wr |=> cfg_rd_out == '0 && sw_reset_out && int_n_out)
    else $error("soft reset did not clear configuration");
  a_zero_reset_inert: assert property (wr_in.en && !wr_in.data[`SMRC_BIT_RESET] |=> !sw_reset_out)
    else $error("reset pulse without reset bit");
  a_write_stores: assert property (wr_in.en && !wr_in.data[`SMRC_BIT_RESET]
    |=> cfg_rd_out[`SMRC_CFG_W-1:0] == $past(wr_in.data[`SMRC_CFG_W-1:0]))
    else $error("write not stored");
  a_crc_self_clear: assert property (crc_finish && !wr_in.en |=> !cfg_rd_out[`SMRC_BIT_CRC])
    else $error("checksum trigger did not clear");
  a_done_irq: assert property (crc_finish && !soft_wr |=> checksum_done_flag_out && !int_n_out)
    else $error("checksum done did not raise interrupt");
  a_result_latched: assert property (crc_finish && !soft_wr |=> crc_result_out == $past(crc_in.value))
    else $error("checksum result not captured");
  a_crc_starts: assert property (cfg_rd_out[`SMRC_BIT_CRC] && !q.busy && !soft_wr
    |=> crc_start_out ##1 !crc_start_out)
    else $error("checksum not started once");
  a_run_starts: assert property (run_out && !soft_wr |=> q.phase != SMRC_IDLE)
    else $error("run bit did not start sampling");
  a_stop_idles: assert property (!run_out |=> !wetting_on_out)
    else $error("sampling while stopped");
  a_continuous_on: assert property (run_out && !periodic_out && wetting_on_out && !soft_wr
    |=> wetting_on_out)
    else $error("continuous mode dropped wetting");

  c_crc_done: cover property (crc_start_out ##[1:50] !int_n_out);
  c_periodic_wait: cover property (periodic_out && q.phase == SMRC_WAIT);
  c_soft_reset: cover property (run_out ##1 sw_reset_out);
  c_restart: cover property (!run_out ##1 run_out ##1 wetting_on_out);

endmodule // smrc_top

// ---- bench/smrc_crc_model.sv ----
// Checksum engine stand-in that answers a start after a set latency
`timescale 1ns/1ps
module smrc_crc_model (
  input wire logic sys_clk_in,
  input wire logic reset_in,
  input wire logic start_in,
  input wire logic [7:0] lat_in,
  input wire logic [15:0] val_in,
  output smrc_pkg::smrc_crc_type crc_out
);
  import smrc_pkg::*;
  int cnt_q;
  // Count down after a start, then pulse done with the value; stale value toggles
  always @(posedge sys_clk_in)
  begin
    if (reset_in)
    begin
      cnt_q <= 0;
      crc_out <= '0;
    end
    else if (cnt_q == 1 && !start_in)
    begin
      crc_out <= '{1'b1, val_in};
      cnt_q <= 0;
    end
    else
    begin
      crc_out <= '{1'b0, ~crc_out.value};
      if (start_in)
        cnt_q <= int'(lat_in) + 1;
      else if (cnt_q > 1)
        cnt_q <= cnt_q - 1;
    end
  end
endmodule // smrc_crc_model

// ---- bench/switch_monitor_run_control_tb.sv ----
// Self-checking bench for the switch monitor run-control block
`timescale 1ns/1ps
module switch_monitor_run_control_tb;
  import smrc_pkg::*;
  typedef struct packed {logic [23:0] data; int win; int per;} smrc_row_type;
  logic sys_clk_in = 1'b0;
  logic reset_in = 1'b1;
  smrc_wr_type wr_in = '0;
  smrc_crc_type crc_in;
  logic flag_clear_in = 1'b0;
  logic [23:0] cfg_rd_out;
  logic [15:0] crc_result_out;
  logic run_out, periodic_out, wetting_on_out, crc_start_out, checksum_done_flag_out, int_n_out, sw_reset_out;
  int err_total = 0;
  int num_checks = 0;
  int n, w;
  smrc_row_type rows [4] = '{'{24'h000C00, 64, 2000}, '{24'hFFFD02, 640, 4000},
    '{24'h000D9A, 2048, 8000}, '{24'h000DE4, 512, 8000}};

  always #12.5 sys_clk_in = ~sys_clk_in;

  smrc_top #(.TICK_CYCLES(1)) uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .wr_in(wr_in),
    .crc_in(crc_in), .flag_clear_in(flag_clear_in), .cfg_rd_out(cfg_rd_out), .run_out(run_out),
    .periodic_out(periodic_out), .wetting_on_out(wetting_on_out), .crc_start_out(crc_start_out),
    .crc_result_out(crc_result_out), .checksum_done_flag_out(checksum_done_flag_out),
    .int_n_out(int_n_out), .sw_reset_out(sw_reset_out));

  smrc_crc_model crc_model (.sys_clk_in(sys_clk_in), .reset_in(reset_in), .start_in(crc_start_out),
    .lat_in(8'h06), .val_in(16'h3C5A), .crc_out(crc_in));

  // Verdict and end of run
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask

  // Compare one value
  task automatic chk(input logic [23:0] seen, input logic [23:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask

  // One register write, returns once the new value is visible
  task automatic wr(input logic [23:0] d);
    @(posedge sys_clk_in);
    wr_in <= '{1'b1, d};
    @(posedge sys_clk_in);
    wr_in.en <= 1'b0;
    #1;
  endtask

  function automatic logic pick(input int sel);
    return sel == 0 ? wetting_on_out : (sel == 1 ? crc_start_out : int_n_out);
  endfunction

  // Bounded wait for a level, giving the number of edges it took
  task automatic wait_on(input int sel, input logic lvl, input int lim, output int cnt);
    cnt = 0;
    while (pick(sel) !== lvl)
    begin
      @(posedge sys_clk_in);
      #1;
      cnt++;
      if (cnt > lim)
      begin
        err_total++;
        complete_run();
      end
    end
  endtask

  // Main sequence
  initial
  begin
    repeat (8) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    #1;
    chk(cfg_rd_out, 24'h000000);
    chk({int_n_out, checksum_done_flag_out, wetting_on_out}, 24'h000004);
    foreach (rows[i])
    begin
      wr(24'h000000);
      wr(rows[i].data);
      chk(cfg_rd_out, {12'h000, rows[i].data[11:0]});
      chk({run_out, periodic_out, sw_reset_out}, 24'h000006);
      wait_on(0, 1'b1, 20, n);
      wait_on(0, 1'b0, 9000, n);
      wait_on(0, 1'b1, 9000, n);
      wait_on(0, 1'b0, 9000, w);
      wait_on(0, 1'b1, 9000, n);
      chk(w >= rows[i].win - 1 && w <= rows[i].win + 1, 24'h000001);
      chk(w + n >= rows[i].per - 1 && w + n <= rows[i].per + 1, 24'h000001);
    end
    wr(24'h000000);
    wr(24'h000800);
    wait_on(0, 1'b1, 2, n);
    repeat (30) @(posedge sys_clk_in);
    #1;
    chk(wetting_on_out, 24'h000001);
    wr(24'h000000);
    repeat (2) @(posedge sys_clk_in);
    #1;
    chk({run_out, wetting_on_out}, 24'h000000);
    wr(24'h000800);
    wr(24'h000A00);
    wait_on(1, 1'b1, 3, n);
    wait_on(2, 1'b0, 20, n);
    chk({checksum_done_flag_out, crc_result_out}, {7'h00, 1'b1, 16'h3C5A});
    chk(cfg_rd_out, 24'h000800);
    @(posedge sys_clk_in);
    flag_clear_in <= 1'b1;
    @(posedge sys_clk_in);
    flag_clear_in <= 1'b0;
    #1;
    chk({int_n_out, checksum_done_flag_out}, 24'h000002);
    wr(24'h000C1E);
    chk(cfg_rd_out, 24'h000C1E);
    wr(24'h000C1F);
    chk(sw_reset_out, 24'h000001);
    chk(cfg_rd_out, 24'h000000);
    chk(crc_result_out, 24'h003C5A);
    @(posedge sys_clk_in);
    #1;
    chk({sw_reset_out, run_out}, 24'h000000);
    // Hardware reset in mid-run while sampling
    wr(24'h000C00);
    @(posedge sys_clk_in);
    reset_in <= 1'b1;
    repeat (2) @(posedge sys_clk_in);
    reset_in <= 1'b0;
    #1;
    chk(cfg_rd_out, 24'h000000);
    chk({run_out, wetting_on_out, int_n_out, checksum_done_flag_out, crc_start_out}, 24'h000004);
    wr(24'h000800);
    wait_on(0, 1'b1, 2, n);
    chk(wetting_on_out, 24'h000001);
    complete_run();
  end
endmodule // switch_monitor_run_control_tb
